// *** pkg/periph_regs_pkg.sv ***
package periph_regs_pkg;

  // Address window sizes in bytes
  localparam int WINDOW_STD_BYTES  = 16384;  // Ordinary peripheral window
  localparam int WINDOW_IRQC_BYTES = 4096;   // Interrupt controller window

  // Bus data width; every register occupies one aligned word
  localparam int BUS_W = 32;

  // Register byte offsets inside the window
  localparam logic [11:0] OFF_CTRL   = 12'h000;  // Command, write only
  localparam logic [11:0] OFF_MODE   = 12'h004;  // Configuration, read/write
  localparam logic [11:0] OFF_STAT   = 12'h008;  // Status, read only
  localparam logic [11:0] OFF_CHEN   = 12'h010;  // Channel enable, write ones
  localparam logic [11:0] OFF_CHDIS  = 12'h014;  // Channel disable, write ones
  localparam logic [11:0] OFF_CHSTAT = 12'h018;  // Channel enable status
  localparam logic [11:0] OFF_IEN    = 12'h020;  // Interrupt enable, write ones
  localparam logic [11:0] OFF_IDIS   = 12'h024;  // Interrupt disable, write ones
  localparam logic [11:0] OFF_IMASK  = 12'h028;  // Interrupt mask, read only
  localparam logic [11:0] OFF_DOUT   = 12'h030;  // Data to the peripheral
  localparam logic [11:0] OFF_DIN    = 12'h034;  // Data from the peripheral

  // Default implemented field widths
  localparam int CMD_W_DEF  = 8;
  localparam int MODE_W_DEF = 16;
  localparam int STAT_W_DEF = 8;
  localparam int CH_W_DEF   = 8;
  localparam int DATA_W_DEF = 32;

  // Reset values
  localparam logic [31:0] MODE_RST  = 32'h0000_0000;
  localparam logic [31:0] DOUT_RST  = 32'h0000_0000;
  localparam logic [31:0] BANK_RST  = 32'h0000_0000;
  localparam logic [31:0] RDATA_RST = 32'h0000_0000;

endpackage

// *** logic/set_clear_bank.sv ***
`timescale 1ns/100ps
// Bit bank changed only by write-one-to-set and write-one-to-clear strobes
module set_clear_bank
#(
  parameter int W = 8
)
(
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  input  wire logic [W-1:0] set_i,
  input  wire logic [W-1:0] clr_i,
  output logic      [W-1:0] q_o
);
  import periph_regs_pkg::*;

  // All state of the bank
  typedef struct packed {
    logic [W-1:0] bits;  // Current bit values
  } bank_type;

  bank_type state_reg;   // Registered state
  bank_type state_next;  // Next state

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb
  begin
    state_next = state_reg;
    state_next.bits = state_next.bits & ~clr_i;
    // Ones set bits
    // Set is applied last so it wins if both strobes ever hit one bit
    state_next.bits = state_next.bits | set_i;
    // Zero bits keep value
    // Falls out of the masking above: zeros touch nothing
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      state_reg.bits <= BANK_RST[W-1:0];
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  assign q_o = state_reg.bits;

endmodule

// *** logic/periph_register_block.sv ***
// Design decisions made here: the placing of the registers and the strobed register port.
`timescale 1ns/100ps
// Notes on behaviour
// - Register data path is 32 bits wide
// - Word access only, low address bits ignored
// - Window of 16 Kbyte, 4 Kbyte for irq controller
// - Command register: write one fires, zero nothing
// - Mode register read/write, resets to zero
// - Status register read only, writes ignored
// - Data registers move values both ways
// - Enable address ones set status bits
// - Disable address ones clear status bits
// - Zero bits on enable/disable change nothing
// - Unused bits read zero, write zero
// - Interrupt is OR of status AND mask
// - Mask readable, changed only via enable/disable
module periph_register_block
  import periph_regs_pkg::*;
#(
  parameter int WINDOW_BYTES = WINDOW_STD_BYTES,
  parameter int CMD_W        = CMD_W_DEF,
  parameter int MODE_W       = MODE_W_DEF,
  parameter int STAT_W       = STAT_W_DEF,
  parameter int CH_W         = CH_W_DEF,
  parameter int DATA_W       = DATA_W_DEF,
  parameter int ADDR_W       = $clog2(WINDOW_BYTES)
)
(
  input  wire logic              clk_i,          // Bus clock
  input  wire logic              rst_n_i,        // Sync reset, active low
  input  wire logic [ADDR_W-1:0] addr_i,         // Byte address in window
  input  wire logic [BUS_W-1:0]  wdata_i,        // Write data
  input  wire logic              wr_i,           // Write strobe
  input  wire logic              rd_i,           // Read strobe
  output logic      [BUS_W-1:0]  rdata_o,        // Read data, cycle after rd_i
  output logic      [CMD_W-1:0]  cmd_o,          // One-cycle command pulses
  output logic      [MODE_W-1:0] mode_o,         // Configuration
  output logic      [DATA_W-1:0] data_out_o,     // Data toward the peripheral
  output logic                   data_out_stb_o, // Pulse when data_out_o written
  input  wire logic [DATA_W-1:0] data_in_i,      // Data from the peripheral
  input  wire logic [STAT_W-1:0] status_i,       // Peripheral condition bits
  output logic      [CH_W-1:0]   chan_en_o,      // Channel enable status
  output logic      [STAT_W-1:0] irq_mask_o,     // Interrupt mask
  output logic                   irq_o           // To vectored_irq_controller
);
  import periph_regs_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Decode helpers
  // Window size sets decode width

  // Low address bits dropped
  // Word hit: the two low address bits never take part, so a byte or
  // half-word access lands on the whole word that holds it
  function automatic logic reg_hit(input logic [ADDR_W-1:0] a,
                                   input logic [11:0]       off);
    reg_hit = ({a[ADDR_W-1:2], 2'b00} == ADDR_W'(off));
  endfunction

  // Any implemented register at this address
  function automatic logic reg_mapped(input logic [ADDR_W-1:0] a);
    reg_mapped = reg_hit(a, OFF_CTRL)  || reg_hit(a, OFF_MODE)   ||
                 reg_hit(a, OFF_STAT)  || reg_hit(a, OFF_CHEN)   ||
                 reg_hit(a, OFF_CHDIS) || reg_hit(a, OFF_CHSTAT) ||
                 reg_hit(a, OFF_IEN)   || reg_hit(a, OFF_IDIS)   ||
                 reg_hit(a, OFF_IMASK) || reg_hit(a, OFF_DOUT)   ||
                 reg_hit(a, OFF_DIN);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // State

  // All state held in this module; set/clear banks live in instances
  typedef struct packed {
    logic [MODE_W-1:0] mode;     // Configuration register
    logic [CMD_W-1:0]  cmd;      // Command pulses
    logic [DATA_W-1:0] dout;     // Outgoing data
    logic              dstb;     // Outgoing data strobe
    logic [STAT_W-1:0] stat;     // Registered status
    logic              irq;      // Interrupt request
    logic [BUS_W-1:0]  rdata;    // Read data
  } state_type;

  state_type         state_reg;   // Registered state
  state_type         state_next;  // Next state
  logic [CH_W-1:0]   ch_set;      // Channel enable strobes
  logic [CH_W-1:0]   ch_clr;      // Channel disable strobes
  logic [STAT_W-1:0] im_set;      // Mask enable strobes
  logic [STAT_W-1:0] im_clr;      // Mask disable strobes
  logic [CH_W-1:0]   ch_q;        // Channel enable bank
  logic [STAT_W-1:0] im_q;        // Mask bank
  logic [STAT_W-1:0] masked;      // Status bits that pass the mask
  logic              irq_raw;     // OR of the masked bits

  ////////////////////////////////////////////////////////////////////////////
  // Strobes toward the set/clear banks

  // Mask enable/disable decode
  // Nothing else can reach the banks, so a mask write at its read
  // address leaves it alone
  always_comb
  begin
    ch_set = '0;
    ch_clr = '0;
    im_set = '0;
    im_clr = '0;
    if (wr_i)
    begin
      if (reg_hit(addr_i, OFF_CHEN))
        ch_set = wdata_i[CH_W-1:0];
      if (reg_hit(addr_i, OFF_CHDIS))
        ch_clr = wdata_i[CH_W-1:0];
      if (reg_hit(addr_i, OFF_IEN))
        im_set = wdata_i[STAT_W-1:0];
      if (reg_hit(addr_i, OFF_IDIS))
        im_clr = wdata_i[STAT_W-1:0];
    end
  end

  // Channel enable/disable/status triplet
  set_clear_bank #(.W(CH_W)) chan_bank (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .set_i   (ch_set),
    .clr_i   (ch_clr),
    .q_o     (ch_q)
  );

  // Interrupt enable/disable/mask triplet
  set_clear_bank #(.W(STAT_W)) mask_bank (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .set_i   (im_set),
    .clr_i   (im_clr),
    .q_o     (im_q)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt source

  genvar gi;
  generate
    for (gi = 0; gi < STAT_W; gi = gi + 1)
    begin : g_mask
      assign masked[gi] = state_reg.stat[gi] & im_q[gi];
    end
  endgenerate

  assign irq_raw = |masked;

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb
  begin
    state_next = state_reg;
    // Commands and the data strobe last one cycle only
    state_next.cmd  = '0;
    state_next.dstb = 1'b0;
    // Status follows the peripheral; it is same-clock logic, no synchroniser
    state_next.stat = status_i;
    // Request is registered so irq_o comes straight from a flop
    state_next.irq  = irq_raw;
    // Read data stands only in the cycle after the strobe
    state_next.rdata = '0;

    if (wr_i)
    begin
      if (reg_hit(addr_i, OFF_CTRL))
        state_next.cmd = wdata_i[CMD_W-1:0];
      if (reg_hit(addr_i, OFF_MODE))
        state_next.mode = wdata_i[MODE_W-1:0];
      if (reg_hit(addr_i, OFF_DOUT))
      begin
        state_next.dout = wdata_i[DATA_W-1:0];
        state_next.dstb = 1'b1;
      end
      // Status writes ignored
      // No branch for the status address: its flops only follow status_i
    end

    if (rd_i)
    begin
      // Unused bits read zero
      // Every field is zero-extended into the 32-bit word
      if (reg_hit(addr_i, OFF_MODE))
        state_next.rdata = BUS_W'(state_reg.mode);
      else if (reg_hit(addr_i, OFF_STAT))
        state_next.rdata = BUS_W'(state_reg.stat);
      else if (reg_hit(addr_i, OFF_CHSTAT))
        state_next.rdata = BUS_W'(ch_q);
      else if (reg_hit(addr_i, OFF_IMASK))
        state_next.rdata = BUS_W'(im_q);
      else if (reg_hit(addr_i, OFF_DOUT))
        state_next.rdata = BUS_W'(state_reg.dout);
      else if (reg_hit(addr_i, OFF_DIN))
        state_next.rdata = BUS_W'(data_in_i);
      else
        // Write-only and unmapped words read as zero
        state_next.rdata = '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      state_reg.mode  <= MODE_RST[MODE_W-1:0];
      state_reg.cmd   <= '0;
      state_reg.dout  <= DOUT_RST[DATA_W-1:0];
      state_reg.dstb  <= 1'b0;
      state_reg.stat  <= '0;
      state_reg.irq   <= 1'b0;
      state_reg.rdata <= RDATA_RST;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, all from flops
  assign rdata_o        = state_reg.rdata;
  assign cmd_o          = state_reg.cmd;
  assign mode_o         = state_reg.mode;
  assign data_out_o     = state_reg.dout;
  assign data_out_stb_o = state_reg.dstb;
  assign chan_en_o      = ch_q;
  assign irq_mask_o     = im_q;
  assign irq_o          = state_reg.irq;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  a_bus_width: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    rd_i && reg_hit(addr_i, OFF_DOUT) |=> rdata_o == BUS_W'($past(data_out_o)))
    else $error("data word not read back on the full bus");

  a_window_size: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (1 << ADDR_W) == WINDOW_BYTES &&
    (WINDOW_BYTES == WINDOW_STD_BYTES || WINDOW_BYTES == WINDOW_IRQC_BYTES))
    else $error("address window size is wrong");

  a_cmd_pulse: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    wr_i && reg_hit(addr_i, OFF_CTRL)
    |=> cmd_o == $past(wdata_i[CMD_W-1:0]) ##1 cmd_o == '0 || $past(wr_i))
    else $error("command pulse wrong");

  // No pulse without a command write
  a_cmd_idle: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !(wr_i && reg_hit(addr_i, OFF_CTRL)) |=> cmd_o == '0)
    else $error("command fired without a write");

  // Mode read at any byte of its word
  a_mode_read: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    rd_i && reg_hit(addr_i, OFF_MODE) |=> rdata_o == BUS_W'($past(mode_o)))
    else $error("mode read mismatch");

  // Status read shows status two cycles back
  a_status_read: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    rd_i && reg_hit(addr_i, OFF_STAT) |=> rdata_o == BUS_W'($past(status_i, 2)))
    else $error("status read mismatch");

  a_chan_set: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    wr_i && reg_hit(addr_i, OFF_CHEN)
    |=> chan_en_o == ($past(chan_en_o) | $past(wdata_i[CH_W-1:0])))
    else $error("channel enable did not set");

  a_chan_clear: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    wr_i && reg_hit(addr_i, OFF_CHDIS)
    |=> chan_en_o == ($past(chan_en_o) & ~$past(wdata_i[CH_W-1:0])))
    else $error("channel disable did not clear");

  a_mask_stable: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !(wr_i && (reg_hit(addr_i, OFF_IEN) || reg_hit(addr_i, OFF_IDIS)))
    |=> $stable(irq_mask_o))
    else $error("mask changed without enable or disable write");

  a_irq_form: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ##2 irq_o == |($past(status_i, 2) & $past(irq_mask_o)))
    else $error("interrupt request not OR of masked status");

  a_reset_quiet: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $rose(rst_n_i) |-> !irq_o && chan_en_o == '0 && irq_mask_o == '0 && mode_o == '0)
    else $error("state not cleared by reset");

  // Unmapped and idle reads are zero
  a_read_zero: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !rd_i || !reg_mapped(addr_i) || reg_hit(addr_i, OFF_CTRL) |=> rdata_o == '0)
    else $error("read data not zero");

endmodule

// *** sim/bus_master_model.sv ***
`timescale 1ns/100ps
// Processor side of the register bus: one request per call, never stalled
module bus_master_model
  import periph_regs_pkg::*;
#(
  parameter int ADDR_W = 14
)
(
  input  wire logic              clk_i,    // Bus clock
  output logic      [ADDR_W-1:0] addr_o,   // Byte address in the window
  output logic      [BUS_W-1:0]  wdata_o,  // Write data
  output logic                   wr_o,     // Write strobe
  output logic                   rd_o,     // Read strobe
  input  wire logic [BUS_W-1:0]  rdata_i   // Read data, cycle after the strobe
);
  // Idle bus at time zero
  initial
  begin
    addr_o  = '0;
    wdata_o = '0;
    wr_o    = 1'b0;
    rd_o    = 1'b0;
  end

  //////////////////////////////////////////////////////////////////////////////
  // One-cycle write; released lines show the inverse so stale data never match
  task automatic write(input logic [15:0] a, input logic [BUS_W-1:0] d);
    @(posedge clk_i);
    addr_o  <= a[ADDR_W-1:0];
    wdata_o <= d;
    wr_o    <= 1'b1;
    @(posedge clk_i);
    wr_o    <= 1'b0;
    addr_o  <= ~a[ADDR_W-1:0];
    wdata_o <= ~d;
  endtask

  // One-cycle read; data taken just after the edge that takes the strobe
  task automatic read(input logic [15:0] a, output logic [BUS_W-1:0] d);
    @(posedge clk_i);
    addr_o <= a[ADDR_W-1:0];
    rd_o   <= 1'b1;
    @(posedge clk_i);
    rd_o   <= 1'b0;
    addr_o <= ~a[ADDR_W-1:0];
    #1;
    d = rdata_i;
  endtask
endmodule

// *** sim/tb.sv ***
`timescale 1ns/100ps
module tb;
  import periph_regs_pkg::*;
  logic                  clk_i, rst_n_i, wr_i, rd_i, data_out_stb_o, irq_o;
  logic [13:0]           addr_i;      // Default 16 Kbyte window
  logic [BUS_W-1:0]      wdata_i, rdata_o, w, d, e, s, exp_ch, exp_mk;
  logic [CMD_W_DEF-1:0]  cmd_o;
  logic [MODE_W_DEF-1:0] mode_o;
  logic [DATA_W_DEF-1:0] data_out_o, data_in_i;
  logic [STAT_W_DEF-1:0] status_i, irq_mask_o;
  logic [CH_W_DEF-1:0]   chan_en_o;
  logic [1:0]            lo;          // Sub-word address bits
  int                    fail_count, n_tests, cycles;

  periph_register_block u_periph_register_block (.clk_i, .rst_n_i, .addr_i, .wdata_i, .wr_i,
    .rd_i, .rdata_o, .cmd_o, .mode_o, .data_out_o, .data_out_stb_o, .data_in_i, .status_i,
    .chan_en_o, .irq_mask_o, .irq_o);
  bus_master_model u_bus_master_model (.clk_i, .addr_o(addr_i), .wdata_o(wdata_i),
    .wr_o(wr_i), .rd_o(rd_i), .rdata_i(rdata_o));

  // 25 MHz clock
  initial
  begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  // Expected interrupt: any status bit that its mask lets through
  function automatic logic irq_exp(input logic [31:0] st, input logic [31:0] mk);
    return |(st[7:0] & mk[7:0]);
  endfunction

  task automatic check(input string name, input logic [31:0] ex, input logic [31:0] got);
    n_tests++;
    if (got !== ex)
    begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", name, ex, got);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [31:0] v);
    u_bus_master_model.write(a, v);
  endtask

  task automatic rdchk(input string name, input logic [15:0] a, input logic [31:0] ex);
    logic [31:0] v;
    u_bus_master_model.read(a, v);
    check(name, ex, v);
  endtask

  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // Hang guard: the whole sequence needs well under 3000 cycles
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      fail_count++;
      finish_test();
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    rst_n_i = 1'b0;
    status_i = '0;
    data_in_i = '0;
    exp_ch = '0;
    exp_mk = '0;
    void'($urandom(32'h325ec1e0));
    repeat (20) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(posedge clk_i);
    #1;
    check("irq after reset", 0, 32'(irq_o));
    rdchk("mode reset", OFF_MODE, MODE_RST);
    rdchk("mask reset", OFF_IMASK, 0);
    $display("reset test done");
    // Mode and command with random sub-word addresses and data masked to field width
    for (int i = 0; i < 8; i++)
    begin
      w = $urandom;
      lo = 2'($urandom);
      wr(OFF_MODE | 12'(lo), w & 32'hffff);
      #1;
      check("mode_o", {16'h0, w[15:0]}, 32'(mode_o));
      rdchk("mode read", OFF_MODE | 12'(lo), {16'h0, w[15:0]});
      wr(OFF_CTRL | 12'(lo), w & 32'hff);
      #1;
      check("cmd pulse", {24'h0, w[7:0]}, 32'(cmd_o));
      @(posedge clk_i);
      #1;
      check("cmd end", 0, 32'(cmd_o));
      rdchk("ctrl read", OFF_CTRL, 0);
    end
    $display("mode and command test done");
    // Data both ways, status read only
    w = $urandom;
    wr(OFF_DOUT, w);
    #1;
    check("data_out", w, data_out_o);
    check("stb high", 1, 32'(data_out_stb_o));
    @(posedge clk_i);
    data_in_i <= $urandom;
    status_i <= 8'($urandom);
    #1;
    check("stb low", 0, 32'(data_out_stb_o));
    rdchk("dout read", OFF_DOUT, w);
    rdchk("din read", OFF_DIN, data_in_i);
    wr(OFF_STAT, 32'(~status_i));
    rdchk("stat read", OFF_STAT, 32'(status_i));
    rdchk("unmapped top", 16'h3ffc, 0);
    wr(16'h0040, 32'hffff);
    rdchk("unmapped hole", 16'h000c, 0);
    $display("data and status test done");
    // Set/clear banks for channels and interrupt mask
    for (int i = 0; i < 16; i++)
    begin
      e = (i == 0) ? 32'h0 : $urandom;
      d = (i == 1) ? 32'h0 : $urandom;
      s = $urandom;
      @(posedge clk_i);
      status_i <= s[7:0];
      wr(OFF_CHEN, e & 32'hff);
      exp_ch = exp_ch | (e & 32'hff);
      #1;
      check("chan set", exp_ch, 32'(chan_en_o));
      wr(OFF_CHDIS, d & 32'hff);
      exp_ch = exp_ch & ~d;
      wr(OFF_CHSTAT, 32'hff);
      rdchk("chan status", OFF_CHSTAT, exp_ch);
      wr(OFF_IEN, (e >> 8) & 32'hff);
      exp_mk = exp_mk | ((e >> 8) & 32'hff);
      wr(OFF_IDIS, (d >> 8) & 32'hff);
      exp_mk = exp_mk & ~(d >> 8);
      wr(OFF_IMASK, 32'hff);
      repeat (2) @(posedge clk_i);
      #1;
      check("irq mask", exp_mk, 32'(irq_mask_o));
      check("irq", 32'(irq_exp(s, exp_mk)), 32'(irq_o));
      check("chan keep", exp_ch, 32'(chan_en_o));
      rdchk("mask read", OFF_IMASK, exp_mk);
    end
    $display("set and clear test done");
    // Reset in mid-run with interrupt active
    @(posedge clk_i);
    status_i <= 8'hff;
    wr(OFF_IEN, 32'hff);
    wr(OFF_CHEN, 32'hff);
    wr(OFF_MODE, 32'hffff);
    repeat (2) @(posedge clk_i);
    #1;
    check("irq before reset", 1, 32'(irq_o));
    @(posedge clk_i);
    rst_n_i <= 1'b0;
    // Two edges in reset so no history check straddles a half-applied reset
    repeat (2) @(posedge clk_i);
    rst_n_i <= 1'b1;
    #1;
    check("irq reset", 0, 32'(irq_o));
    check("chan reset", 0, 32'(chan_en_o));
    check("mask clear", 0, 32'(irq_mask_o));
    rdchk("mode clear", OFF_MODE, MODE_RST);
    $display("mid-run reset test done");
    finish_test();
  end
endmodule
